// ==== grld_gauge_core.sv ====
// Gauge register bank, capacity arithmetic and LED segment display
`timescale 1ns/1ps
module grld_gauge_core import grld_pkg::*; #(
   parameter int TICK_CYC = GRLD_TICK_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire grld_host_req_t hostReq,
   output logic [7:0] hostRdData,
   output logic hostRdValid,
   input wire logic [7:0] measVoltage,
   input wire logic [7:0] measRate,
   input wire logic dischargePulse,
   input wire logic cellCold,
   input wire logic [5:0] pullupSense,
   input wire logic modeStrapHigh,
   input wire logic modeStrapLow,
   input wire logic initSelectStrap,
   input wire logic displayRequestN,
   output logic ledSegmentOne,
   output logic ledSegmentTwo,
   output logic ledSegmentThree,
   output logic ledSegmentFour,
   output logic ledSegmentFive,
   output logic controlPortOe
);

   // Percentage of a 16-bit capacity against a full reference, capped at 125
   function automatic logic [7:0] pctOf(input logic [15:0] cap, input logic [7:0] full);
      logic [23:0] num;
      logic [23:0] q;
      num = 24'(cap) * 24'd100;
      q = (full == 8'h00) ? 24'h000000 : num / 24'({full, 8'h00});
      if (q > 24'(GRLD_REL_MAX)) begin
         q = 24'(GRLD_REL_MAX);
      end
      return q[7:0];
   endfunction

   logic [9:0] pinSync1_ff, pinSync2_ff;
   logic reqLow, initHigh, modeHigh, modeLow;
   logic [5:0] pullups;
   logic [15:0] tickCnt_ff;
   logic tick_ff;
   logic [13:0] secCnt_ff;
   logic secTick_ff;
   logic [6:0] bankPhase_ff;
   logic [10:0] blinkCnt_ff;
   logic blinkOn_ff;
   logic initPending_ff;
   logic [1:0] settle_ff;
   logic doInit, hostWrite, hostRead, resetCmd;
   logic [6:0] addr;
   logic [7:0] pfcNow, pfc_ff, pullupMap_ff, threshold_ff, voltage_ff, rate_ff, peak_ff;
   logic [7:0] full_capacity_ref_ff, rel_ff, primaryFlags, rdMux, level;
   logic [15:0] dcr_ff, cap_ff, nac, derate, cacCalc, fullCount;
   logic initFlag_ff, cpDriveLow_ff, firstEmpty_ff, finalEmpty_ff, finalCond;
   logic [7:0] hostRdData_ff;
   logic hostRdValid_ff;
   grld_dsp_state_t dispState_ff;
   grld_mode_t dispMode_ff, modeNow;
   logic [17:0] showTimer_ff, showLimit;
   logic [4:0] pattern, bankMask, nxtSeg, segVec_ff;

   // Two-flop synchroniser for every strap and request pin; request idles high out of reset
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         pinSync1_ff <= GRLD_PIN_RST;
         pinSync2_ff <= GRLD_PIN_RST;
      end else begin
         pinSync1_ff <= {displayRequestN, initSelectStrap, modeStrapHigh, modeStrapLow, pullupSense};
         pinSync2_ff <= pinSync1_ff;
      end
   end
   assign reqLow = !pinSync2_ff[9];
   assign initHigh = pinSync2_ff[8];
   assign modeHigh = pinSync2_ff[7];
   assign modeLow = pinSync2_ff[6];
   assign pullups = pinSync2_ff[5:0];

   // Base tick divider
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         tickCnt_ff <= 16'h0000;
         tick_ff <= 1'b0;
      end else if (tickCnt_ff == 16'(TICK_CYC - 1)) begin
         tickCnt_ff <= 16'h0000;
         tick_ff <= 1'b1;
      end else begin
         tickCnt_ff <= tickCnt_ff + 16'h0001;
         tick_ff <= 1'b0;
      end
   end

   // One-second strobe for voltage sampling and capacity recompute
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         secCnt_ff <= 14'h0000;
         secTick_ff <= 1'b0;
      end else begin
         secTick_ff <= 1'b0;
         if (tick_ff) begin
            if (secCnt_ff == GRLD_SEC_TICKS - 14'h0001) begin
               secCnt_ff <= 14'h0000;
               secTick_ff <= 1'b1;
            end else begin
               secCnt_ff <= secCnt_ff + 14'h0001;
            end
         end
      end
   end

   // Bank multiplex phase and blink phase; free running so banks never beat
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         bankPhase_ff <= 7'h00;
         blinkCnt_ff <= 11'h000;
         blinkOn_ff <= 1'b0;
      end else if (tick_ff) begin
         bankPhase_ff <= (bankPhase_ff == GRLD_BANK_TICKS - 7'h01) ? 7'h00 : bankPhase_ff + 7'h01;
         if (blinkCnt_ff == GRLD_BLINK_HALF_TICKS - 11'h001) begin
            blinkCnt_ff <= 11'h000;
            blinkOn_ff <= !blinkOn_ff;
         end else begin
            blinkCnt_ff <= blinkCnt_ff + 11'h001;
         end
      end
   end

   assign hostWrite = hostReq.valid && hostReq.cmd[7];
   assign hostRead = hostReq.valid && !hostReq.cmd[7];
   assign addr = hostReq.cmd[6:0];
   assign resetCmd = hostWrite && (addr == GRLD_ADDR_CMD) && (hostReq.data == GRLD_CMD_RESET);

   // Initialisation waits for straps to settle after reset; a command needs no wait
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         initPending_ff <= 1'b1;
         settle_ff <= GRLD_SETTLE_CYCLES;
      end else if (resetCmd) begin
         initPending_ff <= 1'b1;
         settle_ff <= 2'h0;
      end else if (initPending_ff) begin
         if (settle_ff == 2'h0) begin
            initPending_ff <= 1'b0;
         end else begin
            settle_ff <= settle_ff - 2'h1;
         end
      end
   end
   assign doInit = initPending_ff && (settle_ff == 2'h0);
   assign pfcNow = GRLD_PFC_BASE + {1'b0, pullups[3:0], 3'b000};

   // strap map and full count caught at initialisation
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         pullupMap_ff <= 8'h00;
         pfc_ff <= 8'h00;
      end else if (doInit) begin
         pullupMap_ff <= {2'b00, pullups};
         pfc_ff <= pfcNow;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         threshold_ff <= GRLD_THRESH_RST;
      end else if (doInit) begin
         threshold_ff <= GRLD_THRESH_RST;
      end else if (hostWrite && addr == GRLD_ADDR_THRESH) begin
         threshold_ff <= hostReq.data;
      end
   end

   // voltage sampled on the second strobe; rate follows the meter
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         voltage_ff <= 8'h00;
         rate_ff <= 8'h00;
      end else begin
         rate_ff <= measRate;
         if (secTick_ff) begin
            voltage_ff <= measVoltage;
         end
      end
   end

   // peak rate holds the largest rate seen
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         peak_ff <= 8'h00;
      end else if (doInit) begin
         peak_ff <= 8'h00;
      end else if (rate_ff > peak_ff) begin
         peak_ff <= rate_ff;
      end
   end

   // discharge counter; a host write wins over a coincident count
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         dcr_ff <= 16'h0000;
      end else if (doInit) begin
         dcr_ff <= 16'h0000;
      end else if (hostWrite && addr == GRLD_ADDR_DCR_HI) begin
         dcr_ff[15:8] <= hostReq.data;
      end else if (hostWrite && addr == GRLD_ADDR_DCR_LO) begin
         dcr_ff[7:0] <= hostReq.data;
      end else if (dischargePulse && dcr_ff != 16'hFFFF) begin
         dcr_ff <= dcr_ff + 16'h0001;
      end
   end

   // compensated capacity: nominal less rate and temperature derating
   always_comb begin
      fullCount = {full_capacity_ref_ff, 8'h00};
      nac = (dcr_ff >= fullCount) ? 16'h0000 : fullCount - dcr_ff;
      derate = (peak_ff > GRLD_PEAK_LIMIT) ? (nac >> 4) : 16'h0000;
      derate = derate + (cellCold ? (nac >> 5) : 16'h0000);
      cacCalc = nac - derate;
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         full_capacity_ref_ff <= 8'h00;
         cap_ff <= 16'h0000;
         rel_ff <= 8'h00;
      end else if (doInit) begin
         full_capacity_ref_ff <= initHigh ? pfcNow : 8'h00;
         cap_ff <= initHigh ? {pfcNow, 8'h00} : 16'h0000;
         rel_ff <= initHigh ? GRLD_REL_FULL : 8'h00;
      end else if (secTick_ff) begin
         cap_ff <= cacCalc;
         rel_ff <= pctOf(cacCalc, full_capacity_ref_ff);
      end
   end

   // final trip sits a fixed count below the threshold
   assign finalCond = (threshold_ff >= GRLD_FINAL_DROP_CNT) && (voltage_ff < threshold_ff - GRLD_FINAL_DROP_CNT);

   // Flags and control port; first empty follows the compare
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         initFlag_ff <= 1'b0;
         cpDriveLow_ff <= 1'b0;
         firstEmpty_ff <= 1'b0;
         finalEmpty_ff <= 1'b0;
      end else if (doInit) begin
         initFlag_ff <= initHigh;
         cpDriveLow_ff <= 1'b0;
         firstEmpty_ff <= 1'b0;
         finalEmpty_ff <= 1'b0;
      end else begin
         firstEmpty_ff <= voltage_ff < threshold_ff;
         finalEmpty_ff <= finalCond;
         if (hostWrite && addr == GRLD_ADDR_CMD && hostReq.data == GRLD_CMD_CP_LOW) begin
            cpDriveLow_ff <= 1'b1;
         end else if (hostWrite && addr == GRLD_ADDR_CMD && hostReq.data == GRLD_CMD_CP_RELEASE) begin
            cpDriveLow_ff <= 1'b0;
         end
      end
   end

   always_comb begin
      primaryFlags = 8'h00;
      primaryFlags[GRLD_FLAG_INIT] = initFlag_ff;
      primaryFlags[GRLD_FLAG_CPIN] = !cpDriveLow_ff;
      primaryFlags[GRLD_FLAG_FIRST] = firstEmpty_ff;
      primaryFlags[GRLD_FLAG_FINAL] = finalEmpty_ff;
   end

   // read map; unmapped addresses read as zero
   always_comb begin
      case (addr)
         GRLD_ADDR_FLAGS: rdMux = primaryFlags;
         GRLD_ADDR_PULLUP: rdMux = pullupMap_ff;
         GRLD_ADDR_VOLT: rdMux = voltage_ff;
         GRLD_ADDR_REL: rdMux = rel_ff;
         GRLD_ADDR_CAP_LO: rdMux = cap_ff[7:0];
         GRLD_ADDR_CAP_HI: rdMux = cap_ff[15:8];
         GRLD_ADDR_PFC: rdMux = pfc_ff;
         GRLD_ADDR_FULL: rdMux = full_capacity_ref_ff;
         GRLD_ADDR_PEAK: rdMux = peak_ff;
         GRLD_ADDR_RATE: rdMux = rate_ff;
         GRLD_ADDR_THRESH: rdMux = threshold_ff;
         GRLD_ADDR_DCR_HI: rdMux = dcr_ff[15:8];
         GRLD_ADDR_DCR_LO: rdMux = dcr_ff[7:0];
         default: rdMux = 8'h00;
      endcase
   end

   // Read answer one cycle after the request; data holds until the next read
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         hostRdData_ff <= 8'h00;
         hostRdValid_ff <= 1'b0;
      end else begin
         hostRdValid_ff <= hostRead;
         if (hostRead) begin
            hostRdData_ff <= rdMux;
         end
      end
   end

   assign modeNow = modeLow ? GRLD_MODE_INC : (modeHigh ? GRLD_MODE_BIN : GRLD_MODE_BAR);
   assign showLimit = (dispMode_ff == GRLD_MODE_INC) ? GRLD_SHOW_LONG_TICKS : GRLD_SHOW_SHORT_TICKS;

   // Display sequencer; mode is latched at the start so a strap change cannot glitch it
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         dispState_ff <= GRLD_DSP_IDLE;
         dispMode_ff <= GRLD_MODE_BAR;
         showTimer_ff <= 18'h00000;
      end else begin
         case (dispState_ff)
            GRLD_DSP_IDLE: begin
               if (reqLow) begin
                  dispState_ff <= GRLD_DSP_SHOW;
                  dispMode_ff <= modeNow;
                  showTimer_ff <= 18'h00000;
               end
            end
            GRLD_DSP_SHOW: begin
               if (!reqLow) begin
                  dispState_ff <= GRLD_DSP_IDLE;
               end else if (tick_ff) begin
                  if (showTimer_ff == showLimit - 18'h00001) begin
                     dispState_ff <= GRLD_DSP_HOLD;
                  end else begin
                     showTimer_ff <= showTimer_ff + 18'h00001;
                  end
               end
            end
            // held low past the period: stay dark until released
            GRLD_DSP_HOLD: begin
               if (!reqLow) begin
                  dispState_ff <= GRLD_DSP_IDLE;
               end
            end
            default: dispState_ff <= GRLD_DSP_IDLE;
         endcase
      end
   end

   assign level = pctOf(cap_ff, full_capacity_ref_ff);

   // Segment pattern from capacity level; bit 0 is segment one
   always_comb begin
      pattern = 5'h00;
      case (dispMode_ff)
         GRLD_MODE_INC: begin
            if (firstEmpty_ff) pattern = {4'h0, blinkOn_ff};
            else if (level >= 8'd90) pattern = 5'h08;
            else if (level >= 8'd50) pattern = 5'h04;
            else if (level >= 8'd20) pattern = 5'h02;
            else pattern = 5'h01;
         end
         GRLD_MODE_BIN: begin
            if (level >= 8'd70) pattern = 5'h03;
            else if (level >= 8'd40) pattern = 5'h01;
            else if (level >= 8'd10) pattern = 5'h02;
            else pattern = 5'h00;
         end
         GRLD_MODE_BAR: begin
            if (firstEmpty_ff) pattern = {4'h0, blinkOn_ff};
            else if (level >= 8'd80) pattern = 5'h1F;
            else if (level >= 8'd60) pattern = 5'h0F;
            else if (level >= 8'd40) pattern = 5'h07;
            else if (level >= 8'd20) pattern = 5'h03;
            else pattern = 5'h01;
         end
         default: pattern = 5'h00;
      endcase
   end

   // bank windows; the gap between them keeps the two banks from overlapping
   always_comb begin
      if (bankPhase_ff < GRLD_BANK_ON_TICKS) begin
         bankMask = 5'h15;
      end else if (bankPhase_ff >= GRLD_BANK_B_START && bankPhase_ff < GRLD_BANK_B_START + GRLD_BANK_ON_TICKS) begin
         bankMask = 5'h0A;
      end else begin
         bankMask = 5'h00;
      end
   end

   // final empty or released request forces everything dark
   assign nxtSeg = (dispState_ff == GRLD_DSP_SHOW && reqLow && !finalEmpty_ff) ? (pattern & bankMask) : 5'h00;

   // Output register; every pin leaves straight from a flop
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         segVec_ff <= 5'h00;
      end else begin
         segVec_ff <= nxtSeg;
      end
   end

   assign ledSegmentOne = segVec_ff[0];
   assign ledSegmentTwo = segVec_ff[1];
   assign ledSegmentThree = segVec_ff[2];
   assign ledSegmentFour = segVec_ff[3];
   assign ledSegmentFive = segVec_ff[4];
   assign controlPortOe = cpDriveLow_ff;
   assign hostRdData = hostRdData_ff;
   assign hostRdValid = hostRdValid_ff;

   // Checks on the behaviour above
   default clocking dcb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);

   chk_release_dark: assert property (!reqLow |=> segVec_ff == 5'h00)
      else $error("segments lit while request is high");
   chk_final_dark: assert property (finalEmpty_ff |=> segVec_ff == 5'h00)
      else $error("segments lit under final empty");
   chk_bank_split: assert property (!(((segVec_ff & 5'h15) != 5'h00) && ((segVec_ff & 5'h0A) != 5'h00)))
      else $error("both banks active together");
   chk_first_flag: assert property (!doInit |=> firstEmpty_ff == $past(voltage_ff < threshold_ff))
      else $error("first empty flag does not match compare");
   chk_init_full: assert property ((doInit && initHigh) |=> (full_capacity_ref_ff == pfc_ff && cap_ff == {pfc_ff, 8'h00}
      && rel_ff == GRLD_REL_FULL && primaryFlags == GRLD_FLAGS_INIT_HI))
      else $error("init with strap high loaded wrong values");
   chk_init_empty: assert property ((doInit && !initHigh) |=> (full_capacity_ref_ff == 8'h00 && cap_ff == 16'h0000
      && rel_ff == 8'h00 && primaryFlags == GRLD_FLAGS_INIT_LO))
      else $error("init with strap low loaded wrong values");
   chk_rel_bound: assert property (rel_ff <= GRLD_REL_MAX)
      else $error("relative charge above limit");
   chk_peak_hold: assert property (!doInit |=> peak_ff >= $past(rate_ff) && peak_ff >= $past(peak_ff))
      else $error("peak rate lost a maximum");
   chk_volt_hold: assert property ((!secTick_ff && rstn) |=> $stable(voltage_ff))
      else $error("voltage changed off the second strobe");
   chk_bad_write: assert property ((hostWrite && addr != GRLD_ADDR_THRESH && !initPending_ff)
      |=> $stable(threshold_ff))
      else $error("write to unmapped address changed state");
   chk_show_limit: assert property (dispState_ff == GRLD_DSP_SHOW |-> showTimer_ff < showLimit)
      else $error("display period overran");

   cov_show_inc: cover property (dispState_ff == GRLD_DSP_SHOW && dispMode_ff == GRLD_MODE_INC && segVec_ff != 5'h00);
   cov_show_bin: cover property (dispState_ff == GRLD_DSP_SHOW && dispMode_ff == GRLD_MODE_BIN && segVec_ff == 5'h03);
   cov_show_bar: cover property (dispState_ff == GRLD_DSP_SHOW && dispMode_ff == GRLD_MODE_BAR && segVec_ff == 5'h15);
   cov_period_end: cover property (dispState_ff == GRLD_DSP_SHOW ##1 dispState_ff == GRLD_DSP_HOLD);
endmodule

// ==== grld_pkg.sv ====
// Constants, types and register layout for the gauge register bank and LED display
// Overview of operation
// - Pull-up strap map flags each detected pull-up
// - Battery voltage register refreshed once per second
// - Threshold sets first trip; final 100mV lower
// - Relative charge is capacity over full, max 125%
// - Compensated capacity drives the display pattern
// - Expose programmed full count and full reference
// - Peak rate holds maximum, feeds compensation
// - Present rate register shows current discharge rate
// - Discharge counter counts up; writes alter capacity
// - Mode strap: low incremental, high binary, float bar
// - Segments dark while request high, lit when low
// - Banks 1-3-5 and 2-4 alternate, 100Hz, 30%
// - Segment one blinks 4Hz on first empty, except in binary mode
// - Final empty turns every segment off
// - Incremental: one of four segments, ten seconds
// - Binary: two segments, four seconds, 70/40/10
// - Bar graph: cumulative segments, four seconds
// - Writing 78h to command word reinitialises
// - Init strap high loads full count defaults
// - Init strap low clears capacity, flags 10h
// - First empty flag tracks voltage below threshold
// - Command bit 7 write, 7-bit address; bad writes ignored
package grld_pkg;
   // Timing: one base tick, everything slower counts ticks
   localparam int GRLD_CLK_PERIOD_NS = 25;
   localparam int GRLD_TICK_NS = 100_000;
   localparam int GRLD_TICK_CYCLES = (GRLD_TICK_NS + GRLD_CLK_PERIOD_NS - 1) / GRLD_CLK_PERIOD_NS;
   localparam int GRLD_TICKS_PER_S = 1_000_000_000 / GRLD_TICK_NS;
   localparam int GRLD_BANK_HZ = 100;
   localparam int GRLD_BANK_DUTY_PCT = 30;
   localparam int GRLD_BLINK_HZ = 4;
   localparam int GRLD_SHOW_LONG_S = 10;
   localparam int GRLD_SHOW_SHORT_S = 4;
   localparam logic [6:0] GRLD_BANK_TICKS = 7'(GRLD_TICKS_PER_S / GRLD_BANK_HZ);
   localparam logic [6:0] GRLD_BANK_ON_TICKS = 7'(GRLD_TICKS_PER_S / GRLD_BANK_HZ * GRLD_BANK_DUTY_PCT / 100);
   localparam logic [6:0] GRLD_BANK_B_START = 7'(GRLD_TICKS_PER_S / GRLD_BANK_HZ / 2);
   localparam logic [10:0] GRLD_BLINK_HALF_TICKS = 11'(GRLD_TICKS_PER_S / (2 * GRLD_BLINK_HZ));
   localparam logic [13:0] GRLD_SEC_TICKS = 14'(GRLD_TICKS_PER_S);
   localparam logic [17:0] GRLD_SHOW_LONG_TICKS = 18'(GRLD_SHOW_LONG_S * GRLD_TICKS_PER_S);
   localparam logic [17:0] GRLD_SHOW_SHORT_TICKS = 18'(GRLD_SHOW_SHORT_S * GRLD_TICKS_PER_S);
   localparam logic [1:0] GRLD_SETTLE_CYCLES = 2'h3;
   // Register addresses
   localparam logic [6:0] GRLD_ADDR_CMD = 7'h00;
   localparam logic [6:0] GRLD_ADDR_FLAGS = 7'h01;
   localparam logic [6:0] GRLD_ADDR_PULLUP = 7'h08;
   localparam logic [6:0] GRLD_ADDR_VOLT = 7'h0B;
   localparam logic [6:0] GRLD_ADDR_REL = 7'h0D;
   localparam logic [6:0] GRLD_ADDR_CAP_LO = 7'h0E;
   localparam logic [6:0] GRLD_ADDR_CAP_HI = 7'h0F;
   localparam logic [6:0] GRLD_ADDR_PFC = 7'h10;
   localparam logic [6:0] GRLD_ADDR_FULL = 7'h11;
   localparam logic [6:0] GRLD_ADDR_PEAK = 7'h12;
   localparam logic [6:0] GRLD_ADDR_RATE = 7'h13;
   localparam logic [6:0] GRLD_ADDR_THRESH = 7'h14;
   localparam logic [6:0] GRLD_ADDR_DCR_HI = 7'h15;
   localparam logic [6:0] GRLD_ADDR_DCR_LO = 7'h16;
   // Values and field positions
   localparam logic [7:0] GRLD_THRESH_RST = 8'hA2;
   localparam logic [7:0] GRLD_CMD_RESET = 8'h78;
   localparam logic [7:0] GRLD_CMD_CP_RELEASE = 8'h55;
   localparam logic [7:0] GRLD_CMD_CP_LOW = 8'h66;
   localparam logic [7:0] GRLD_FLAGS_INIT_HI = 8'h90;
   localparam logic [7:0] GRLD_FLAGS_INIT_LO = 8'h10;
   localparam logic [7:0] GRLD_REL_FULL = 8'h64;
   localparam logic [7:0] GRLD_REL_MAX = 8'h7D;
   localparam logic [7:0] GRLD_PFC_BASE = 8'h40;
   localparam logic [7:0] GRLD_PEAK_LIMIT = 8'h80;
   localparam logic [9:0] GRLD_PIN_RST = 10'h200;
   localparam int GRLD_FULL_SCALE_MV = 1200;
   localparam int GRLD_FINAL_DROP_MV = 100;
   localparam logic [7:0] GRLD_FINAL_DROP_CNT = 8'(GRLD_FINAL_DROP_MV * 256 / GRLD_FULL_SCALE_MV);
   localparam int GRLD_FLAG_INIT = 7;
   localparam int GRLD_FLAG_CPIN = 4;
   localparam int GRLD_FLAG_FIRST = 1;
   localparam int GRLD_FLAG_FINAL = 0;
   typedef enum logic [1:0] {GRLD_MODE_INC, GRLD_MODE_BIN, GRLD_MODE_BAR} grld_mode_t;
   typedef enum logic [1:0] {GRLD_DSP_IDLE, GRLD_DSP_SHOW, GRLD_DSP_HOLD} grld_dsp_state_t;
   // One host transaction: command byte plus write data byte
   typedef struct packed {
      logic valid;
      logic [7:0] cmd;
      logic [7:0] data;
   } grld_host_req_t;
endpackage

// ==== grld_host_model.sv ====
// Host model that issues byte-level register reads and writes
`timescale 1ns/1ps
module grld_host_model import grld_pkg::*; (
   input wire logic sys_clk,
   output grld_host_req_t hostReq,
   input wire logic [7:0] hostRdData,
   input wire logic hostRdValid,
   output logic timedOut
);
   initial hostReq = '0;
   initial timedOut = 1'b0;
   // Bit 7 marks a write, low seven bits address
   task automatic xfer(input logic wr, input logic [6:0] addr, input logic [7:0] data, output logic [7:0] rdData);
      int n;
      n = 0;
      hostReq <= '{1'b1, {wr, addr}, data};
      @(posedge sys_clk);
      hostReq <= '0;
      // Writes give no answer; three edges cover a reinit too
      if (wr) begin
         repeat (3) @(posedge sys_clk);
      end else begin
         @(negedge sys_clk);
         while (hostRdValid !== 1'b1 && n < 8) begin
            @(negedge sys_clk);
            n++;
         end
         if (n == 8) timedOut = 1'b1;
         rdData = hostRdData;
         @(posedge sys_clk);
      end
   endtask
endmodule

// ==== tb_gauge_registers_led_display.sv ====
// Self-checking bench for the gauge register bank and LED display
`timescale 1ns/1ps
module tb_gauge_registers_led_display import grld_pkg::*;;
   localparam int TICK = 1; // One tick a cycle keeps the held-period test short
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   grld_host_req_t hostReq;
   logic [7:0] hostRdData;
   logic hostRdValid;
   logic hostTimeout;
   logic [7:0] measVoltage = 8'hC0;
   logic [7:0] measRate = 8'h10;
   logic dischargePulse = 1'b0;
   logic [5:0] pullupSense = 6'h25;
   logic modeStrapHigh = 1'b0;
   logic modeStrapLow = 1'b1;
   logic initSelectStrap = 1'b1;
   logic displayRequestN = 1'b1;
   wire [4:0] seg;
   logic cpOe;
   logic [7:0] rdVal;
   logic [23:0] rows [25];
   int lit;
   int failures = 0;
   int n_checks = 0;
   always #12.5 sys_clk = ~sys_clk;
   grld_gauge_core #(.TICK_CYC(TICK)) u_dut (.sys_clk(sys_clk), .rstn(rstn), .hostReq(hostReq),
      .hostRdData(hostRdData), .hostRdValid(hostRdValid), .measVoltage(measVoltage), .measRate(measRate),
      .dischargePulse(dischargePulse), .cellCold(1'b0), .pullupSense(pullupSense), .modeStrapHigh(modeStrapHigh),
      .modeStrapLow(modeStrapLow), .initSelectStrap(initSelectStrap), .displayRequestN(displayRequestN),
      .ledSegmentOne(seg[0]), .ledSegmentTwo(seg[1]), .ledSegmentThree(seg[2]), .ledSegmentFour(seg[3]),
      .ledSegmentFive(seg[4]), .controlPortOe(cpOe));
   grld_host_model u_host (.sys_clk(sys_clk), .hostReq(hostReq), .hostRdData(hostRdData),
      .hostRdValid(hostRdValid), .timedOut(hostTimeout));
   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Compare one byte; a stuck read ends the run early
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
      if (hostTimeout === 1'b1) begin
         failures++;
         print_verdict();
      end
   endtask
   // Any 800-cycle span holds eight bank periods, so each lit segment shows 240 cycles
   task automatic show(input int mode, input logic [4:0] mask);
      int cnt [5];
      cnt = '{default: 0};
      modeStrapLow <= (mode == 0);
      modeStrapHigh <= (mode == 1);
      repeat (4) @(posedge sys_clk);
      displayRequestN <= 1'b0;
      repeat (8) @(posedge sys_clk);
      repeat (800) begin
         @(negedge sys_clk);
         for (int s = 0; s < 5; s++) cnt[s] += int'(seg[s] === 1'b1);
      end
      for (int s = 0; s < 5; s++) check(8'(cnt[s]), mask[s] ? 8'hF0 : 8'h00); // pattern and duty
      @(posedge sys_clk);
      displayRequestN <= 1'b1;
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk);
      check({3'h0, seg}, 8'h00); // dark once released
      @(posedge sys_clk);
   endtask
   // Rows: command byte, write data, expected read byte
   initial begin
      rows[0] = 24'h080025;
      rows[1] = 24'h0B00C0;
      rows[2] = 24'h0D0064;
      rows[3] = 24'h0E0000;
      rows[4] = 24'h0F0068;
      rows[5] = 24'h100068;
      rows[6] = 24'h110068;
      rows[7] = 24'h120010;
      rows[8] = 24'h130010;
      rows[9] = 24'h010090;
      rows[10] = 24'h1400A2;
      rows[11] = 24'h94C800;
      rows[12] = 24'h010092;
      rows[13] = 24'h8D0000;
      rows[14] = 24'h0D0064;
      rows[15] = 24'h7F0000;
      rows[16] = 24'h951200;
      rows[17] = 24'h150012;
      rows[18] = 24'h807800;
      rows[19] = 24'h110000;
      rows[20] = 24'h0F0000;
      rows[21] = 24'h0D0000;
      rows[22] = 24'h010010;
      rows[23] = 24'h806600;
      rows[24] = 24'h010000;
   end
   initial begin
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      // One full second so the voltage sample and recompute have landed
      repeat (GRLD_TICKS_PER_S * TICK + 200) @(posedge sys_clk);
      show(0, 5'h08); // full cell
      show(1, 5'h03); // full cell
      show(2, 5'h1F); // full cell
      // A threshold far above the cell raises the final flag
      u_host.xfer(1'b1, GRLD_ADDR_THRESH, 8'hFF, rdVal);
      show(1, 5'h00); // final empty darkens even the binary code
      u_host.xfer(1'b1, GRLD_ADDR_THRESH, GRLD_THRESH_RST, rdVal);
      initSelectStrap <= 1'b0;
      for (int i = 0; i < 25; i++) begin
         u_host.xfer(rows[i][23], rows[i][22:16], rows[i][15:8], rdVal); // row stimulus
         if (rows[i][23] == 1'b0) check(rdVal, rows[i][7:0]); // row expectation
      end
      check({7'h00, cpOe}, 8'h01); // control port driven low
      u_host.xfer(1'b1, GRLD_ADDR_CMD, GRLD_CMD_CP_RELEASE, rdVal);
      check({7'h00, cpOe}, 8'h00); // control port released
      // Counter wraps its low byte into the high byte
      u_host.xfer(1'b1, GRLD_ADDR_DCR_LO, 8'hFE, rdVal);
      dischargePulse <= 1'b1;
      repeat (3) @(posedge sys_clk);
      dischargePulse <= 1'b0;
      u_host.xfer(1'b0, GRLD_ADDR_DCR_HI, 8'h00, rdVal);
      check(rdVal, 8'h01); // carry
      u_host.xfer(1'b0, GRLD_ADDR_DCR_LO, 8'h00, rdVal);
      check(rdVal, 8'h01); // wrap
      show(0, 5'h01); // empty cell
      show(1, 5'h00); // empty cell
      show(2, 5'h01); // empty cell
      // Held past the bar period: dark until the request is renewed
      displayRequestN <= 1'b0;
      lit = 0;
      repeat (GRLD_SHOW_SHORT_S * GRLD_TICKS_PER_S * TICK + 100) @(posedge sys_clk);
      repeat (200) begin
         @(negedge sys_clk);
         lit += int'(seg !== 5'h00);
      end
      check(8'(lit), 8'h00); // dark after the period
      @(posedge sys_clk);
      displayRequestN <= 1'b1;
      show(2, 5'h01); // a fresh press lights again
      print_verdict();
   end
endmodule
